// file: src/ssc_pkg.sv
/*
  Shared constants and carrier types of the software style block.
  Assumes a single clock domain and an APB register port.
*/
package ssc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_STYLE_PRI = 8'h00;
  localparam logic [7:0] OFS_STYLE_ALIAS = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_INIT_HI = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Style register fields
  localparam int STYLE_LSB = 0;
  localparam int STYLE_W = 8;
  localparam int WIDE_BIT = 8;
  localparam int PAR_EN_BIT = 10;
  // Control register fields
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_SUSP_BIT = 1;
  localparam int CTRL_IOW_BIT = 2;
  // Style codes
  localparam logic [7:0] STYLE_LEGACY = 8'h00;
  localparam logic [7:0] STYLE_RES1 = 8'h01;
  localparam logic [7:0] STYLE_WIDE = 8'h02;
  localparam logic [7:0] STYLE_WIDE_BURST = 8'h03;
  // Reset values
  localparam logic [7:0] STYLE_RST = 8'h00;
  localparam logic [7:0] INIT_HI_RST = 8'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // Master address split
  localparam int HI_LSB = 24;
  localparam int HI_W = 8;
  // Interrupt events
  localparam int EV_REJECT = 0;
  localparam int EV_BUF_PAR = 1;
  localparam int EV_OTHER_PAR = 2;
  localparam int EV_N = 3;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_ACC = 2'b10
  } ssc_phase_t;

  typedef struct packed {
    logic dataErr;
    logic addrErr;
    logic asTarget;
    logic onRx;
  } ssc_par_ev_t;

  typedef struct packed {
    logic req;
    logic [31:0] ptr;
  } ssc_mst_t;

  typedef struct packed {
    logic wide;
    logic burstDesc;
    logic reserved;
  } ssc_layout_t;

  typedef struct packed {
    ssc_phase_t phase;
    logic [7:0] style;
    logic parEn;
    logic stop;
    logic susp;
    logic ioWide;
    logic [7:0] initHigh;
    logic [31:0] rdata;
    logic bpeRx;
    logic bpeTx;
    logic parRep;
  } ssc_regs_t;

  typedef struct packed {
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic irq;
  } ssc_irq_t;

  typedef struct packed {
    logic [31:0] addr;
    logic valid;
  } ssc_addr_t;
endpackage : ssc_pkg

// file: src/ssc_sticky_irq.sv
/*
  Sticky event status, mask and level interrupt.
  Assumes events are one-cycle pulses on the block clock.
*/
`timescale 1ns/1ps
module ssc_sticky_irq
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events and software access
  input wire logic [ssc_pkg::EV_N-1:0] ev,
  input wire logic clrEn,
  input wire logic [ssc_pkg::EV_N-1:0] clrBits,
  input wire logic maskWe,
  input wire logic [ssc_pkg::EV_N-1:0] maskIn,
  // Results
  output ssc_pkg::ssc_irq_t irqState
);
  import ssc_pkg::*;

  ssc_irq_t q;
  ssc_irq_t next_q;

  always_comb
  begin
    next_q = q;
    // Set beats a clear in the same cycle
    if (clrEn)
    begin
      next_q.status = q.status & ~clrBits;
    end
    next_q.status = next_q.status | ev;
    if (maskWe)
    begin
      next_q.mask = maskIn;
    end
    next_q.irq = |(next_q.status & next_q.mask);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign irqState = q;

  property p_evSticks;
    @(posedge clk) disable iff (!rst_n)
      ev[EV_REJECT] |=> q.status[EV_REJECT];
  endproperty
  a_evSticks: assert property (p_evSticks)
    else $error("event did not set its status bit");
endmodule : ssc_sticky_irq

// file: src/ssc_addr_gen.sv
/*
  Master address former: narrow styles borrow the stored top byte.
  Assumes pointer requests arrive as one-cycle strobes.
*/
`timescale 1ns/1ps
module ssc_addr_gen
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request and mode
  input ssc_pkg::ssc_mst_t mstReq,
  input wire logic wide,
  input wire logic [7:0] initHigh,
  // Address out
  output ssc_pkg::ssc_addr_t busAddr,
  output logic busAddrOe
);
  import ssc_pkg::*;

  ssc_addr_t q;
  ssc_addr_t next_q;

  always_comb
  begin
    next_q = q;
    next_q.valid = mstReq.req;
    if (mstReq.req)
    begin
      if (wide)
      begin
        next_q.addr = mstReq.ptr;
      end
      else
      begin
        // Narrow structures carry only 24 address bits
        next_q.addr = {initHigh, mstReq.ptr[HI_LSB-1:0]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign busAddr = q;
  assign busAddrOe = 1'b1;

  property p_narrowHigh;
    @(posedge clk) disable iff (!rst_n)
      (mstReq.req && !wide) |=>
        busAddr.addr[HI_LSB+HI_W-1:HI_LSB] == $past(initHigh);
  endproperty
  a_narrowHigh: assert property (p_narrowHigh)
    else $error("narrow address top byte wrong");

  property p_widePtr;
    @(posedge clk) disable iff (!rst_n)
      (mstReq.req && wide) |=>
        (busAddr.addr == $past(mstReq.ptr)) && busAddr.valid;
  endproperty
  a_widePtr: assert property (p_widePtr)
    else $error("wide address not taken from pointer");
endmodule : ssc_addr_gen

// file: src/ssc_style_regs.sv
/*
  Software style register bank with APB slave, parity steering,
  master address forming and a sticky interrupt.
  Assumes an APB master on clk and pointer and parity strobes
  from the DMA engine in the same domain.
*/
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Primary and alias reach the same storage
// - Enabled master data parity flags descriptor
// - Address and target parity always reported
// - Parity enable writable only halted or suspended
// - Wide flag derived from style, read-only
// - Wide flag selects descriptor format width
// - Narrow mode takes stored top address byte
// - Wide mode uses full pointers
// - Upper address lines always driven
// - I/O width from its own bit
// - Style alters only layout-related behaviour
// - Style resets to zero, halted writes only
// - Reserved bits written zero, read zero
// - Decode codes 0, 2, 3; rest reserved (code 1 is flagged reserved but also decodes as wide)
module ssc_style_regs
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssc_pkg::ADDR_W-1:0] paddr,
  input wire logic [ssc_pkg::DATA_W-1:0] pwdata,
  output logic [ssc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parity events and descriptor flag strobes
  input ssc_pkg::ssc_par_ev_t parEv,
  output logic bpeSetRx,
  output logic bpeSetTx,
  output logic parReport,
  // Master addressing
  input ssc_pkg::ssc_mst_t mstReq,
  output ssc_pkg::ssc_addr_t busAddr,
  output logic busAddrOe,
  // Mode outputs
  output ssc_pkg::ssc_layout_t layout,
  output logic ioWide,
  output logic halted,
  // Interrupt
  output logic irq
);
  import ssc_pkg::*;

  ssc_regs_t q;
  ssc_regs_t next_q;
  ssc_irq_t irqState;
  ssc_layout_t lay;
  logic access;
  logic wrEn;
  logic styleHit;
  logic mapped;
  logic canWrite;
  logic rejectEv;
  logic masterData;
  logic bpeEv;
  logic otherEv;
  logic [EV_N-1:0] events;
  logic [DATA_W-1:0] styleWord;
  logic [DATA_W-1:0] readVal;

  // Style decode
  always_comb
  begin
    lay.wide = (q.style == STYLE_RES1) || (q.style == STYLE_WIDE)
      || (q.style == STYLE_WIDE_BURST);
    lay.burstDesc = (q.style == STYLE_WIDE_BURST);
    lay.reserved = (q.style != STYLE_LEGACY)
      && (q.style != STYLE_WIDE)
      && (q.style != STYLE_WIDE_BURST);
  end

  // Only layout signals depend on style
  assign layout = lay;
  assign ioWide = q.ioWide;
  assign halted = q.stop || q.susp;
  assign canWrite = q.stop || q.susp;

  // Bus decode
  assign access = psel && penable;
  assign pready = (q.phase == PH_ACC);
  assign wrEn = access && pready && pwrite;
  assign styleHit = (paddr == OFS_STYLE_PRI)
    || (paddr == OFS_STYLE_ALIAS);
  assign mapped = styleHit || (paddr == OFS_CTRL)
    || (paddr == OFS_INIT_HI) || (paddr == OFS_IRQ_STAT)
    || (paddr == OFS_IRQ_MASK);
  assign pslverr = access && pready && !mapped;
  assign prdata = q.rdata;

  // Reserved bits read back as zero
  always_comb
  begin
    styleWord = DATA_ZERO;
    styleWord[STYLE_LSB +: STYLE_W] = q.style;
    styleWord[WIDE_BIT] = lay.wide;
    styleWord[PAR_EN_BIT] = q.parEn;
  end

  always_comb
  begin
    readVal = DATA_ZERO;
    if (styleHit)
    begin
      readVal = styleWord;
    end
    else if (paddr == OFS_CTRL)
    begin
      readVal[CTRL_STOP_BIT] = q.stop;
      readVal[CTRL_SUSP_BIT] = q.susp;
      readVal[CTRL_IOW_BIT] = q.ioWide;
    end
    else if (paddr == OFS_INIT_HI)
    begin
      readVal[HI_W-1:0] = q.initHigh;
    end
    else if (paddr == OFS_IRQ_STAT)
    begin
      readVal[EV_N-1:0] = irqState.status;
    end
    else if (paddr == OFS_IRQ_MASK)
    begin
      readVal[EV_N-1:0] = irqState.mask;
    end
  end

  // Parity steering
  assign masterData = parEv.dataErr && !parEv.asTarget;
  assign bpeEv = masterData && q.parEn;
  // Without the enable, master data errors fall back to plain report
  assign otherEv = parEv.addrErr
    || (parEv.dataErr && parEv.asTarget)
    || (masterData && !q.parEn);
  assign rejectEv = wrEn && styleHit && !canWrite;

  always_comb
  begin
    events = '0;
    events[EV_REJECT] = rejectEv;
    events[EV_BUF_PAR] = bpeEv;
    events[EV_OTHER_PAR] = otherEv;
  end

  always_comb
  begin
    next_q = q;
    next_q.bpeRx = bpeEv && parEv.onRx;
    next_q.bpeTx = bpeEv && !parEv.onRx;
    next_q.parRep = otherEv;
    unique case (q.phase)
      PH_IDLE:
      begin
        if (psel && !penable)
        begin
          next_q.rdata = readVal;
          next_q.phase = PH_ACC;
        end
      end
      PH_ACC:
      begin
        next_q.phase = PH_IDLE;
      end
      default:
      begin
        next_q.phase = PH_IDLE;
      end
    endcase
    if (wrEn)
    begin
      if (styleHit && canWrite)
      begin
        // Wide flag bit is ignored on write
        next_q.style = pwdata[STYLE_LSB +: STYLE_W];
        next_q.parEn = pwdata[PAR_EN_BIT];
      end
      if (paddr == OFS_CTRL)
      begin
        next_q.stop = pwdata[CTRL_STOP_BIT];
        next_q.susp = pwdata[CTRL_SUSP_BIT];
        next_q.ioWide = pwdata[CTRL_IOW_BIT];
      end
      if (paddr == OFS_INIT_HI)
      begin
        next_q.initHigh = pwdata[HI_W-1:0];
      end
    end
  end

  // Only hardware reset clears the style; soft stop keeps it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.phase <= PH_IDLE;
      q.style <= STYLE_RST;
      q.parEn <= 1'b0;
      q.stop <= 1'b1;
      q.susp <= 1'b0;
      q.ioWide <= 1'b0;
      q.initHigh <= INIT_HI_RST;
      q.rdata <= DATA_ZERO;
      q.bpeRx <= 1'b0;
      q.bpeTx <= 1'b0;
      q.parRep <= 1'b0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign bpeSetRx = q.bpeRx;
  assign bpeSetTx = q.bpeTx;
  assign parReport = q.parRep;
  assign irq = irqState.irq;

  ssc_sticky_irq u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .ev(events),
    .clrEn(wrEn && (paddr == OFS_IRQ_STAT)),
    .clrBits(pwdata[EV_N-1:0]),
    .maskWe(wrEn && (paddr == OFS_IRQ_MASK)),
    .maskIn(pwdata[EV_N-1:0]),
    .irqState(irqState)
  );

  ssc_addr_gen u_addr (
    .clk(clk),
    .rst_n(rst_n),
    .mstReq(mstReq),
    .wide(lay.wide),
    .initHigh(q.initHigh),
    .busAddr(busAddr),
    .busAddrOe(busAddrOe)
  );

  property p_aliasRead;
    @(posedge clk) disable iff (!rst_n)
      (psel && !penable && pready == 1'b0
        && paddr == OFS_STYLE_ALIAS)
      |=> prdata[STYLE_W-1:0] == $past(q.style);
  endproperty
  a_aliasRead: assert property (p_aliasRead)
    else $error("alias read differs from style storage");

  property p_aliasWrite;
    @(posedge clk) disable iff (!rst_n)
      (wrEn && paddr == OFS_STYLE_ALIAS && canWrite)
      |=> q.style == $past(pwdata[STYLE_W-1:0]);
  endproperty
  a_aliasWrite: assert property (p_aliasWrite)
    else $error("alias write did not reach style storage");

  property p_rejectKeeps;
    @(posedge clk) disable iff (!rst_n)
      (wrEn && styleHit && !canWrite)
      |=> $stable(q.style) && $stable(q.parEn)
        && irqState.status[EV_REJECT];
  endproperty
  a_rejectKeeps: assert property (p_rejectKeeps)
    else $error("running-state write changed style");

  property p_parEnWrite;
    @(posedge clk) disable iff (!rst_n)
      (wrEn && styleHit && canWrite)
      |=> q.parEn == $past(pwdata[PAR_EN_BIT]);
  endproperty
  a_parEnWrite: assert property (p_parEnWrite)
    else $error("parity enable not written while halted");

  property p_wideRead;
    @(posedge clk) disable iff (!rst_n)
      (pready && styleHit && access && !pwrite)
      |-> prdata[WIDE_BIT] == ((prdata[STYLE_W-1:0] == STYLE_WIDE)
        || (prdata[STYLE_W-1:0] == STYLE_WIDE_BURST)
        || (prdata[STYLE_W-1:0] == STYLE_RES1));
  endproperty
  a_wideRead: assert property (p_wideRead)
    else $error("wide flag does not match style");

  property p_bpeSet;
    @(posedge clk) disable iff (!rst_n)
      (parEv.dataErr && !parEv.asTarget && q.parEn && parEv.onRx)
      |=> bpeSetRx && !bpeSetTx;
  endproperty
  a_bpeSet: assert property (p_bpeSet)
    else $error("receive buffer parity flag not raised");

  property p_addrParity;
    @(posedge clk) disable iff (!rst_n)
      (parEv.addrErr || (parEv.dataErr && parEv.asTarget))
      |=> parReport ##1 irqState.status[EV_OTHER_PAR];
  endproperty
  a_addrParity: assert property (p_addrParity)
    else $error("address or target parity not reported");

  property p_rsvdZero;
    @(posedge clk) disable iff (!rst_n)
      (pready && styleHit && access && !pwrite)
      |-> prdata[DATA_W-1:PAR_EN_BIT+1] == '0 && !prdata[WIDE_BIT+1];
  endproperty
  a_rsvdZero: assert property (p_rsvdZero)
    else $error("reserved style bits not zero");

  property p_bpeTxSet;
    @(posedge clk) disable iff (!rst_n)
      (parEv.dataErr && !parEv.asTarget && q.parEn && !parEv.onRx)
      |=> bpeSetTx && !bpeSetRx;
  endproperty
  a_bpeTxSet: assert property (p_bpeTxSet)
    else $error("transmit buffer parity flag not raised");

  // Flag must stay quiet without the enable
  property p_bpeGated;
    @(posedge clk) disable iff (!rst_n)
      !q.parEn |=> !bpeSetRx && !bpeSetTx;
  endproperty
  a_bpeGated: assert property (p_bpeGated)
    else $error("buffer parity flag raised while disabled");

  property p_legacyLayout;
    @(posedge clk) disable iff (!rst_n)
      (q.style == STYLE_LEGACY)
      |-> !layout.wide && !layout.burstDesc && !layout.reserved;
  endproperty
  a_legacyLayout: assert property (p_legacyLayout)
    else $error("legacy style decoded as wide or reserved");

  property p_styleHeld;
    @(posedge clk) disable iff (!rst_n)
      !(wrEn && styleHit && canWrite)
      |=> $stable(q.style) && $stable(q.parEn);
  endproperty
  a_styleHeld: assert property (p_styleHeld)
    else $error("style changed without an allowed write");
endmodule : ssc_style_regs

// file: verification/ssc_apb_host.sv
/*
  APB host model: single word reads and writes, one at a time.
  Assumes the slave answers with pready on the rising edge of clk.
*/
`timescale 1ns/1ps
module ssc_apb_host
  import ssc_pkg::*;
(
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ssc_pkg::ADDR_W-1:0] paddr,
  output logic [ssc_pkg::DATA_W-1:0] pwdata,
  input wire logic [ssc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import ssc_pkg::*;
  logic [31:0] rdata;
  logic err;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // No wait limit here; the bench watchdog ends a hang
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : ~pwdata;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep its last value
    pwdata <= ~pwdata;
    #1;
  endtask : xfer

  // Reserved style bits always written as zero
  task wrStyle(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d & 32'h0000_05FF);
  endtask : wrStyle
endmodule : ssc_apb_host

// file: verification/tb_top.sv
/*
  Self-checking bench of the style register block with a model.
  Assumes the APB host model and a 10 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import ssc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] prdata, pwdata, ptr;
  ssc_par_ev_t parEv;
  ssc_mst_t mstReq;
  ssc_addr_t busAddr;
  ssc_layout_t layout;
  logic bpeSetRx, bpeSetTx, parReport, busAddrOe, ioWide, halted, irq;
  logic de, ae, tg, rx, eRep;
  integer seed;
  int miscompares, n_tests, mStyle, mPar, mHi, mStat;
  logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'hFF, 8'h03};

  ssc_style_regs uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .parEv(parEv),
    .bpeSetRx(bpeSetRx), .bpeSetTx(bpeSetTx), .parReport(parReport),
    .mstReq(mstReq), .busAddr(busAddr), .busAddrOe(busAddrOe),
    .layout(layout), .ioWide(ioWide), .halted(halted), .irq(irq));
  ssc_apb_host host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic wideOf(input logic [7:0] c);
    return c inside {8'h01, 8'h02, 8'h03};
  endfunction : wideOf

  function automatic logic [31:0] expStyle();
    return {21'h0, mPar[0], 1'b0, wideOf(mStyle[7:0]), mStyle[7:0]};
  endfunction : expStyle

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_tests++;
    if (seen !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000);
    chk(nm, host.rdata, e);
  endtask : rdchk

  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Whole run is far below this span
  initial
  begin
    #(30000 * 100);
    miscompares++;
    tally_and_finish;
  end

  initial
  begin
    seed = 32'h18be_0bb2;
    miscompares = 0;
    n_tests = 0;
    rst_n = 1'b0;
    parEv = '0;
    mstReq = '0;
    mStyle = 0;
    mPar = 0;
    mStat = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("style", OFS_STYLE_PRI, expStyle());
    rdchk("ctrl", OFS_CTRL, 32'h0000_0001);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      mStyle = codes[i];
      mPar = i % 2;
      host.wrStyle(i % 2 ? OFS_STYLE_ALIAS : OFS_STYLE_PRI,
        32'h0000_0100 | codes[i] | (mPar << 10));
      rdchk("style", i % 2 ? OFS_STYLE_PRI : OFS_STYLE_ALIAS,
        expStyle());
      chk("wide", layout.wide, wideOf(codes[i]));
      chk("burst", layout.burstDesc, codes[i] == 8'h03);
      chk("rsvd", layout.reserved, !(codes[i] inside {0, 2, 3}));
    end
    $display("style code test done");
    host.xfer(1'b1, OFS_CTRL, 32'h0000_0000);
    chk("halted", halted, 1'b0);
    host.wrStyle(OFS_STYLE_PRI, 32'h0000_0002);
    rdchk("style", OFS_STYLE_ALIAS, expStyle());
    rdchk("stat", OFS_IRQ_STAT, 32'h0000_0001);
    chk("irq", irq, 1'b0);
    host.xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", irq, 1'b1);
    host.xfer(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
    rdchk("stat", OFS_IRQ_STAT, 32'h0000_0000);
    chk("irq", irq, 1'b0);
    // Suspend also opens the style register
    host.xfer(1'b1, OFS_CTRL, 32'h0000_0006);
    chk("halted", halted, 1'b1);
    chk("ioWide", ioWide, 1'b1);
    $display("refusal and interrupt test done");
    for (int k = 1; k >= 0; k--)
    begin
      mPar = k;
      host.wrStyle(OFS_STYLE_PRI, 32'h0000_0003 | (k << 10));
      for (int v = 0; v < 16; v++)
      begin
        @(posedge clk);
        parEv <= v[3:0];
        @(posedge clk);
        parEv <= '0;
        #1;
        {de, ae, tg, rx} = v[3:0];
        eRep = ae | (de & tg) | (de & !tg & !k[0]);
        chk("bpeRx", bpeSetRx, de & !tg & k[0] & rx);
        chk("bpeTx", bpeSetTx, de & !tg & k[0] & !rx);
        chk("report", parReport, eRep);
        if (de & !tg & k[0])
          mStat = mStat | 2;
        if (eRep)
          mStat = mStat | 4;
      end
      rdchk("stat", OFS_IRQ_STAT, mStat);
      host.xfer(1'b1, OFS_IRQ_STAT, 32'h0000_0007);
      mStat = 0;
    end
    $display("parity test done");
    for (int n = 0; n < 4; n++)
    begin
      mStyle = n[0] ? 2 : 0;
      mHi = $random(seed) & 255;
      host.wrStyle(OFS_STYLE_PRI, mStyle);
      host.xfer(1'b1, OFS_INIT_HI, mHi);
      rdchk("initHi", OFS_INIT_HI, mHi);
      ptr = $random(seed);
      @(posedge clk);
      mstReq <= '{req: 1'b1, ptr: ptr};
      @(posedge clk);
      mstReq.req <= 1'b0;
      #1;
      chk("valid", busAddr.valid, 1'b1);
      chk("addr", busAddr.addr,
        n[0] ? ptr : {mHi[7:0], ptr[23:0]});
      chk("oe", busAddrOe, 1'b1);
    end
    $display("master address test done");
    // Mid-run hardware reset must clear a non-zero style
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mStyle = 0;
    mPar = 0;
    #1;
    chk("irq", irq, 1'b0);
    rdchk("style", OFS_STYLE_ALIAS, expStyle());
    rdchk("ctrl", OFS_CTRL, 32'h0000_0001);
    rdchk("initHi", OFS_INIT_HI, 32'h0000_0000);
    chk("wide", layout.wide, 1'b0);
    $display("mid-run reset test done");
    host.xfer(1'b0, 8'h20, 32'h0000_0000);
    chk("pslverr", host.err, 1'b1);
    chk("rdata", host.rdata, 32'h0000_0000);
    $display("unmapped test done");
    tally_and_finish;
  end
endmodule : tb_top
